// file: shared/uhc_consts.svh
// constants of the uart host-config block: register indices, field positions, reset values
// assumes a 32-bit word per register; byte address is four times the index
`ifndef UHC_CONSTS_SVH
`define UHC_CONSTS_SVH
`define UHC_IDX_DIV_LOW 3'h0
`define UHC_IDX_TX_HOLD 3'h0
`define UHC_IDX_DIV_HIGH 3'h1
`define UHC_IDX_ENH 3'h2
`define UHC_IDX_FIFO_CTL 3'h2
`define UHC_IDX_LINE 3'h3
`define UHC_IDX_STATUS 3'h5
`define UHC_IDX_DIV_FRAC 3'h7
`define UHC_IDX_HOLE_LOW 3'h4
`define UHC_IDX_HOLE_HIGH 3'h6
`define UHC_LINE_LEN_MSB 1
`define UHC_LEN_MAX 2'h3
`define UHC_BYTE_MASK 8'hff
`define UHC_IDX_LSB 2
`define UHC_IDX_MSB 4
`define UHC_KEY_ENH 8'hbf
`define UHC_ENH_ENABLE_BIT 4
`define UHC_LINE_DIVACC_BIT 7
`define UHC_LINE_BREAK_BIT 6
`define UHC_LINE_EVEN_BIT 4
`define UHC_LINE_PAR_BIT 3
`define UHC_LINE_STOP_BIT 2
`define UHC_FCTL_EN_BIT 0
`define UHC_FCTL_TXCLR_BIT 2
`define UHC_STAT_EMPTY_BIT 0
`define UHC_STAT_FULL_BIT 1
`define UHC_STAT_BUSY_BIT 2
`define UHC_STAT_FEN_BIT 3
`define UHC_RST_LINE 8'h00
`define UHC_RST_DIV_LOW 8'h01
`define UHC_RST_BYTE 8'h00
`define UHC_LAST_TICK 4'hf
`define UHC_FRAC_BITS 6
`define UHC_MIN_LAST_BIT 3'h4
`define UHC_FIFO_DEPTH 32
`define UHC_RESP_OKAY 2'h0
`define UHC_RESP_SLVERR 2'h2
`endif

// file: shared/uhc_pkg.sv
// types shared by the uart host-config block
// assumes uhc_consts.svh is included by the files that need numbers
package uhc_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uhc_tx_state_t;
   typedef logic [7:0] uhc_byte_t;
endpackage : uhc_pkg

// file: src/uhc_fifo.sv
// synchronous fifo with valid/ready on both sides and a clear input
// assumes depth is a power of two; clear wins over a push in the same cycle
`timescale 1ns/1ns
module uhc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic full;
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   always_ff @(posedge aclk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || clear) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : uhc_fifo

// file: src/uhc_baud.sv
// 16x oversampling tick generator with a divisor of integer plus n/64
// assumes divisor and fraction are stable while characters are sent
`timescale 1ns/1ns
`include "uhc_consts.svh"
module uhc_baud (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] divisor,
   input wire logic [`UHC_FRAC_BITS-1:0] fraction,
   output logic tick
);
   logic [15:0] cnt_reg;
   logic [`UHC_FRAC_BITS-1:0] acc_reg;
   logic extra_reg;
   logic [`UHC_FRAC_BITS:0] sum;
   logic [15:0] limit;
   // carry out of the 1/64 accumulator stretches one period by a clock
   assign sum = {1'b0, acc_reg} + {1'b0, fraction};
   assign limit = divisor - 16'h0001 + {15'h0000, extra_reg};
   always_ff @(posedge aclk) begin
      if (!aresetn || divisor == 16'h0000) begin
         cnt_reg <= 16'h0000;
         acc_reg <= '0;
         extra_reg <= 1'b0;
         tick <= 1'b0;
      end else if (cnt_reg >= limit) begin
         cnt_reg <= 16'h0000;
         acc_reg <= sum[`UHC_FRAC_BITS-1:0];
         extra_reg <= sum[`UHC_FRAC_BITS];
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : uhc_baud

// file: src/uhc_top.sv
// uart host-config front end: axi4-lite register set, banked maps, tx fifo, transmitter
// assumes one axi4-lite master; byte lane 0 carries each 8-bit register
//
// Summary of operation
// - each serial bit lasts sixteen ticks; tick period is the divisor
// - divisor has a fraction in sixty-fourths added to the integer part
// - with divisor access open, index 7 write sets the fraction
// - line control 0xbf opens the enhanced register at index 2
// - enhanced value with bit 4 set enables the fractional divisor
// - line control 0x93 gives 8n1 and opens divisor bytes at 1 and 0
// - line control 0x13 restores normal map, keeping 8n1
// - fifo control 0x06 clears the transmit fifo; 0x01 enables fifo operation
// - normal-map write at index 0 queues the byte and sends it unaided
`timescale 1ns/1ns
`include "uhc_consts.svh"
module uhc_top
   import uhc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic txd
);
   ////////////////////////////////////////////////////////////////////////////////
   // registers
   uhc_byte_t line_control_reg;
   uhc_byte_t divisor_low_byte_reg;
   uhc_byte_t divisor_high_byte_reg;
   uhc_byte_t divisor_fraction_reg;
   uhc_byte_t enhanced_feature_control_reg;
   logic fifo_enable_reg;
   logic div_open;
   logic enh_open;
   logic [`UHC_FRAC_BITS-1:0] frac_eff;
   logic baud_tick;

   assign div_open = line_control_reg[`UHC_LINE_DIVACC_BIT];
   assign enh_open = line_control_reg == `UHC_KEY_ENH;
   assign frac_eff = enhanced_feature_control_reg[`UHC_ENH_ENABLE_BIT] ?
                     divisor_fraction_reg[`UHC_FRAC_BITS-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////////
   // write channel
   logic [2:0] wr_idx_reg;
   uhc_byte_t wr_byte_reg;
   logic wr_lane_reg;
   logic wr_pending;
   logic sel_line;
   logic sel_div_low;
   logic sel_div_high;
   logic sel_frac;
   logic sel_enh;
   logic sel_fctl;
   logic sel_tx_hold;
   logic wr_unmapped;
   logic wr_push;
   logic tx_room;
   logic do_write;
   logic fifo_clear;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   uhc_byte_t fifo_out_data;

   assign wr_pending = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign sel_line = wr_idx_reg == `UHC_IDX_LINE;
   // divisor bytes appear while divisor access is open
   assign sel_div_low = div_open && wr_idx_reg == `UHC_IDX_DIV_LOW;
   assign sel_div_high = div_open && wr_idx_reg == `UHC_IDX_DIV_HIGH;
   // fraction written at index 7 under divisor access
   assign sel_frac = div_open && wr_idx_reg == `UHC_IDX_DIV_FRAC;
   assign sel_enh = enh_open && wr_idx_reg == `UHC_IDX_ENH;
   assign sel_fctl = !enh_open && wr_idx_reg == `UHC_IDX_FIFO_CTL;
   // clear divisor bit returns index 0 to transmit holding
   assign sel_tx_hold = !div_open && wr_idx_reg == `UHC_IDX_TX_HOLD;
   assign wr_unmapped = wr_idx_reg == `UHC_IDX_HOLE_LOW || wr_idx_reg == `UHC_IDX_HOLE_HIGH;
   assign wr_push = sel_tx_hold && wr_lane_reg;
   // without fifo mode only one byte waits at a time
   assign tx_room = fifo_enable_reg ? fifo_in_ready : (fifo_in_ready && !fifo_out_valid);
   // a full fifo stalls the write response until there is room
   assign do_write = wr_pending && !(wr_push && !tx_room);
   // clear bit empties the transmit fifo
   assign fifo_clear = do_write && sel_fctl && wr_lane_reg && wr_byte_reg[`UHC_FCTL_TXCLR_BIT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         wr_idx_reg <= 3'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         wr_idx_reg <= s_axi_awaddr[`UHC_IDX_MSB:`UHC_IDX_LSB];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         wr_byte_reg <= `UHC_RST_BYTE;
         wr_lane_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wr_byte_reg <= s_axi_wdata[7:0];
         wr_lane_reg <= s_axi_wstrb[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `UHC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_unmapped ? `UHC_RESP_SLVERR : `UHC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_control_reg <= `UHC_RST_LINE;
         divisor_low_byte_reg <= `UHC_RST_DIV_LOW;
         divisor_high_byte_reg <= `UHC_RST_BYTE;
         divisor_fraction_reg <= `UHC_RST_BYTE;
         enhanced_feature_control_reg <= `UHC_RST_BYTE;
         fifo_enable_reg <= 1'b0;
      end else if (do_write && wr_lane_reg) begin
         if (sel_line) begin
            line_control_reg <= wr_byte_reg;
         end
         if (sel_div_low) begin
            divisor_low_byte_reg <= wr_byte_reg;
         end
         if (sel_div_high) begin
            divisor_high_byte_reg <= wr_byte_reg;
         end
         if (sel_frac) begin
            divisor_fraction_reg <= wr_byte_reg;
         end
         if (sel_enh) begin
            enhanced_feature_control_reg <= wr_byte_reg;
         end
         // enable bit turns on fifo mode
         if (sel_fctl) begin
            fifo_enable_reg <= wr_byte_reg[`UHC_FCTL_EN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read channel
   logic [2:0] rd_idx;
   logic tx_busy_reg;
   logic [31:0] rd_word;
   logic rd_unmapped;

   assign rd_idx = s_axi_araddr[`UHC_IDX_MSB:`UHC_IDX_LSB];
   assign rd_unmapped = rd_idx == `UHC_IDX_HOLE_LOW || rd_idx == `UHC_IDX_HOLE_HIGH;

   always_comb begin
      rd_word = 32'h00000000;
      case (rd_idx)
         `UHC_IDX_DIV_LOW: begin
            if (div_open) begin
               rd_word[7:0] = divisor_low_byte_reg;
            end
         end
         `UHC_IDX_DIV_HIGH: begin
            if (div_open) begin
               rd_word[7:0] = divisor_high_byte_reg;
            end
         end
         `UHC_IDX_ENH: begin
            if (enh_open) begin
               rd_word[7:0] = enhanced_feature_control_reg;
            end
         end
         `UHC_IDX_LINE: begin
            rd_word[7:0] = line_control_reg;
         end
         `UHC_IDX_STATUS: begin
            rd_word[`UHC_STAT_EMPTY_BIT] = !fifo_out_valid;
            rd_word[`UHC_STAT_FULL_BIT] = !fifo_in_ready;
            rd_word[`UHC_STAT_BUSY_BIT] = tx_busy_reg;
            rd_word[`UHC_STAT_FEN_BIT] = fifo_enable_reg;
         end
         `UHC_IDX_DIV_FRAC: begin
            if (div_open) begin
               rd_word[7:0] = divisor_fraction_reg;
            end
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `UHC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_unmapped ? `UHC_RESP_SLVERR : `UHC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit fifo and baud generator
   // byte queued on an index 0 write
   uhc_fifo #(
      .WIDTH(8),
      .DEPTH(`UHC_FIFO_DEPTH)
   ) u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(fifo_clear),
      .in_valid(do_write && wr_push),
      .in_ready(fifo_in_ready),
      .in_data(wr_byte_reg),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   uhc_baud u_baud (
      .aclk(aclk),
      .aresetn(aresetn),
      .divisor({divisor_high_byte_reg, divisor_low_byte_reg}),
      .fraction(frac_eff),
      .tick(baud_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter
   uhc_tx_state_t state_reg;
   logic [3:0] tick_cnt_reg;
   logic [2:0] bit_cnt_reg;
   logic [1:0] nbits_reg;
   logic par_en_reg;
   logic two_stop_reg;
   logic stop_cnt_reg;
   logic parity_reg;
   uhc_byte_t shift_reg;
   uhc_byte_t data_masked;
   logic bit_end;
   logic line_level;

   // transmitter pulls from the fifo whenever idle
   assign fifo_out_ready = state_reg == TX_IDLE;
   assign bit_end = baud_tick && tick_cnt_reg == `UHC_LAST_TICK;
   assign data_masked = fifo_out_data &
                        (`UHC_BYTE_MASK >> (`UHC_LEN_MAX - line_control_reg[`UHC_LINE_LEN_MSB:0]));

   always_ff @(posedge aclk) begin
      if (!aresetn || state_reg == TX_IDLE) begin
         tick_cnt_reg <= 4'h0;
      end else if (baud_tick) begin
         tick_cnt_reg <= tick_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= TX_IDLE;
         bit_cnt_reg <= 3'h0;
         nbits_reg <= 2'h0;
         par_en_reg <= 1'b0;
         two_stop_reg <= 1'b0;
         stop_cnt_reg <= 1'b0;
         parity_reg <= 1'b0;
         shift_reg <= `UHC_RST_BYTE;
      end else begin
         case (state_reg)
            TX_IDLE: begin
               if (fifo_out_valid) begin
                  shift_reg <= data_masked;
                  nbits_reg <= line_control_reg[`UHC_LINE_LEN_MSB:0];
                  par_en_reg <= line_control_reg[`UHC_LINE_PAR_BIT];
                  two_stop_reg <= line_control_reg[`UHC_LINE_STOP_BIT];
                  parity_reg <= line_control_reg[`UHC_LINE_EVEN_BIT] ?
                                (^data_masked) : !(^data_masked);
                  state_reg <= TX_START;
               end
            end
            TX_START: begin
               if (bit_end) begin
                  bit_cnt_reg <= 3'h0;
                  state_reg <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (bit_end) begin
                  shift_reg <= {1'b0, shift_reg[7:1]};
                  bit_cnt_reg <= bit_cnt_reg + 3'h1;
                  stop_cnt_reg <= 1'b0;
                  if (bit_cnt_reg == {1'b0, nbits_reg} + `UHC_MIN_LAST_BIT) begin
                     state_reg <= par_en_reg ? TX_PARITY : TX_STOP;
                  end
               end
            end
            TX_PARITY: begin
               if (bit_end) begin
                  state_reg <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (bit_end) begin
                  stop_cnt_reg <= 1'b1;
                  if (stop_cnt_reg == two_stop_reg) begin
                     state_reg <= TX_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   // low start, data, parity, high stop
   always_comb begin
      case (state_reg)
         TX_START: line_level = 1'b0;
         TX_DATA: line_level = shift_reg[0];
         TX_PARITY: line_level = parity_reg;
         default: line_level = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd <= 1'b1;
         tx_busy_reg <= 1'b0;
      end else begin
         txd <= line_level && !line_control_reg[`UHC_LINE_BREAK_BIT];
         tx_busy_reg <= state_reg != TX_IDLE;
      end
   end
endmodule : uhc_top

// file: testbench/uhc_chk.sv
// checker for the uart host-config top: bus handshakes and serial line
// assumes it is bound to uhc_top and sees only its ports
`timescale 1ns/1ns
module uhc_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic txd
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_r_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] inside {3'h4, 3'h6}
      |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
   a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr[4:2] != 3'h0 |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   a_bit_min: assert property ($fell(txd) |=> !txd [*8])
      else $error("low bit on line too short");
   cover property ($fell(txd));
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] == 3'h7);
endmodule : uhc_chk
bind uhc_top uhc_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd);

// file: testbench/uhc_line_rx.sv
// serial line listener at the far end of txd: decodes 8n1 characters
// assumes a fixed bit length in clocks, known to the bench
`timescale 1ns/1ns
module uhc_line_rx #(
   parameter int BIT = 40
) (
   input wire logic aclk,
   input wire logic rxd
);
   logic [7:0] q[$];
   int unsigned t0[$];
   int unsigned now = 0;
   int frame_err = 0;
   logic [7:0] b;
   always @(posedge aclk) begin
      now <= now + 1;
   end
   always begin
      @(negedge rxd);
      t0.push_back(now);
      repeat (BIT / 2) @(posedge aclk);
      if (rxd !== 1'b0) frame_err++;
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge aclk);
         b[i] = rxd;
      end
      repeat (BIT) @(posedge aclk);
      if (rxd !== 1'b1) frame_err++;
      q.push_back(b);
   end
endmodule : uhc_line_rx

// file: testbench/testbench.sv
// self-checking bench for uhc_top: register rows, transmit, fifo fill and clear, reset
// assumes uhc_line_rx listens on txd with a bit of 40 clocks (divisor 2 + 32/64)
`timescale 1ns/1ns
`include "uhc_consts.svh"
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, (e), (a)); end end
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [3:0] wstrb = 4'h1;
   logic awready, wready, bvalid, arready, rvalid, txd;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rv;
   int failures = 0;
   int cmp_count = 0;
   // cycles that bready or rready stay low before the master raises them
   int lag = 0;
   logic [2:0] ix;
   logic w, er;
   logic [7:0] d, e;
   // index, write, data, read value, refused
   // divisor, then format, then fifo reset
   logic [20:0] rows [14] = '{
      {3'h3, 1'b1, 8'hbf, 8'hbf, 1'b0}, {3'h2, 1'b1, 8'h10, 8'h10, 1'b0},
      {3'h3, 1'b1, 8'h93, 8'h93, 1'b0}, {3'h1, 1'b1, 8'h00, 8'h00, 1'b0},
      {3'h0, 1'b1, 8'h02, 8'h02, 1'b0}, {3'h7, 1'b1, 8'h20, 8'h20, 1'b0},
      {3'h3, 1'b1, 8'h13, 8'h13, 1'b0}, {3'h2, 1'b0, 8'h00, 8'h00, 1'b0},
      {3'h0, 1'b0, 8'h00, 8'h00, 1'b0}, {3'h2, 1'b1, 8'h06, 8'h00, 1'b0},
      {3'h2, 1'b1, 8'h01, 8'h00, 1'b0}, {3'h5, 1'b0, 8'h00, 8'h09, 1'b0},
      {3'h4, 1'b0, 8'h00, 8'h00, 1'b1}, {3'h6, 1'b1, 8'h5a, 8'h00, 1'b1}};
   always #25 aclk = ~aclk;
   uhc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .txd(txd));
   uhc_line_rx #(.BIT(40)) u_rx (.aclk(aclk), .rxd(txd));
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task hang;
      failures++;
      $display("ERROR wait expected answer seen none");
      tally_and_finish();
   endtask : hang
   task automatic wr(input logic [2:0] idx, input logic [7:0] dv, output logic [1:0] resp);
      int n;
      awaddr <= {27'h0, idx, 2'h0};
      wdata <= {24'h0, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (n == lag) bready <= 1'b1;
         if (bvalid === 1'b1 && bready) break;
      end
      resp = bresp;
      if (n == 2000) hang();
   endtask : wr
   task automatic rd(input logic [2:0] idx, output logic [31:0] dv, output logic [1:0] resp);
      int n;
      araddr <= {27'h0, idx, 2'h0};
      arvalid <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (n == lag) rready <= 1'b1;
         if (rvalid === 1'b1 && rready) break;
      end
      dv = rdata;
      resp = rresp;
      if (n == 2000) hang();
   endtask : rd
   task automatic wait_rx(input int k);
      int c;
      for (c = 0; c < 20000 && u_rx.q.size() < k; c++) @(posedge aclk);
      if (c == 20000) hang();
   endtask : wait_rx
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 14; i++) begin
         {ix, w, d, e, er} = rows[i];
         if (w) begin
            wr(ix, d, rs);
            `CHK("bresp", er ? `UHC_RESP_SLVERR : `UHC_RESP_OKAY, rs)
         end
         rd(ix, rv, rs);
         `CHK("rresp", er ? `UHC_RESP_SLVERR : `UHC_RESP_OKAY, rs)
         if (!er) `CHK("rdata", e, rv[7:0])
      end
      $display("test register rows done");
      wr(`UHC_IDX_TX_HOLD, 8'haa, rs);
      wr(`UHC_IDX_TX_HOLD, 8'h3c, rs);
      wait_rx(2);
      `CHK("char0", 8'haa, u_rx.q[0])
      `CHK("char1", 8'h3c, u_rx.q[1])
      `CHK("frame", 1'b1, (u_rx.t0[1] - u_rx.t0[0]) inside {[398:405]})
      $display("test transmit done");
      for (int i = 0; i < 33; i++) wr(`UHC_IDX_TX_HOLD, i[7:0], rs);
      rd(`UHC_IDX_STATUS, rv, rs);
      `CHK("full", 4'he, rv[3:0])
      wr(`UHC_IDX_FIFO_CTL, 8'h06, rs);
      rd(`UHC_IDX_STATUS, rv, rs);
      `CHK("cleared", 4'h5, rv[3:0])
      wr(`UHC_IDX_FIFO_CTL, 8'h01, rs);
      wr(`UHC_IDX_TX_HOLD, 8'h5a, rs);
      wait_rx(4);
      repeat (800) @(posedge aclk);
      `CHK("char2", 8'h00, u_rx.q[2])
      `CHK("char3", 8'h5a, u_rx.q[3])
      `CHK("count", 4, u_rx.q.size())
      `CHK("stop", 0, u_rx.frame_err)
      $display("test fifo fill and clear done");
      // seven bits, odd parity: listener sees the parity bit as its bit 7
      wr(`UHC_IDX_LINE, 8'h0a, rs);
      wr(`UHC_IDX_TX_HOLD, 8'h2a, rs);
      wait_rx(5);
      `CHK("parity", 8'h2a, u_rx.q[4])
      `CHK("stop7", 0, u_rx.frame_err)
      lag = 5;
      bready <= 1'b0;
      rready <= 1'b0;
      wr(`UHC_IDX_LINE, 8'h13, rs);
      `CHK("bresp_lag", `UHC_RESP_OKAY, rs)
      rd(`UHC_IDX_LINE, rv, rs);
      `CHK("rdata_lag", 8'h13, rv[7:0])
      lag = 0;
      wstrb <= 4'h0;
      wr(`UHC_IDX_LINE, 8'h1b, rs);
      `CHK("bresp_nostrb", `UHC_RESP_OKAY, rs)
      wstrb <= 4'h1;
      rd(`UHC_IDX_LINE, rv, rs);
      `CHK("line_nostrb", 8'h13, rv[7:0])
      $display("test parity, back-pressure and strobe done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("txd", 1'b1, txd)
      rd(`UHC_IDX_LINE, rv, rs);
      `CHK("line", `UHC_RST_LINE, rv[7:0])
      rd(`UHC_IDX_STATUS, rv, rs);
      `CHK("status", 8'h01, rv[7:0])
      wr(`UHC_IDX_LINE, 8'h80, rs);
      rd(`UHC_IDX_DIV_LOW, rv, rs);
      `CHK("div_low", `UHC_RST_DIV_LOW, rv[7:0])
      wr(`UHC_IDX_LINE, 8'h40, rs);
      repeat (2) @(posedge aclk);
      `CHK("break", 1'b0, txd)
      $display("test reset done");
      tally_and_finish();
   end
endmodule : testbench
